/* File: logic/pit_consts.svh */
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH
// ----------------------------------------------------------------
// Address unit costs
// ----------------------------------------------------------------
`define PIT_AU_BASE 8'h02
`define PIT_FP_BASE 8'h03
`define PIT_FP_QUAD 8'h02
`define PIT_BOTH_MEM 8'h02
`define PIT_MODE_MREL 8'h03
`define PIT_MODE_EXT 8'h08
`define PIT_MODE_SIDX 8'h02
// ----------------------------------------------------------------
// Interlock stall lengths
// ----------------------------------------------------------------
`define PIT_STALL_BASE1 8'h03
`define PIT_STALL_BASE2 8'h01
`define PIT_STALL_IDX1 8'h01
`define PIT_STALL_WIDTH 8'h02
`define PIT_STALL_MEM1 8'h04
`define PIT_STALL_MEM2 8'h02
`define PIT_STALL_DCACHE 8'h01
`define PIT_STALL_BRPAIR 8'h02
// ----------------------------------------------------------------
// Loader, sizes, conditions, address fields
// ----------------------------------------------------------------
`define PIT_FLD_ONE 2'h1
`define PIT_FLD_TWO 2'h2
`define PIT_SZ_BYTE 2'h0
`define PIT_SZ_WORD 2'h1
`define PIT_SZ_DWORD 2'h2
`define PIT_NOT_EQUAL_CONDITION 4'h1
`define PIT_LESS_OR_EQUAL_CONDITION 4'hD
`define PIT_ADDR_MSB 11
`define PIT_ADDR_DW_LSB 2
`define PIT_REG_NUM_MSB 2
`define PIT_CNT_ZERO 9'h000
`define PIT_CNT_ONE 9'h001
`endif

/* File: logic/pit_field_loader.sv */
`timescale 1ns/1ps
`include "pit_consts.svh"
module pit_field_loader (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic field_valid_in,
  input wire pit_pkg::pit_field_t field_in,
  output logic field_ready_out,
  output logic [1:0] field_cycles_out
);
  import pit_pkg::*;

  logic extra_q, extra_d; // One more cycle owed on the field just taken.
  logic prev_dw_q, prev_dw_d; // Last field taken was a double-word.
  logic [1:0] cyc_q, cyc_d; // Cycles spent on the last field.
  logic take; // Field accepted this cycle.

  // ----------------------------------------------------------------
  // Field handshake
  // ----------------------------------------------------------------
  // One field per cycle unless an extra cycle is still owed.
  assign field_ready_out = ce_in && !extra_q;
  assign take = field_valid_in && field_ready_out;
  assign field_cycles_out = cyc_q;

  // Next values; only an owed cycle slows the loader.
  always_comb begin
    extra_d = extra_q;
    prev_dw_d = prev_dw_q;
    cyc_d = cyc_q;
    if (ce_in && extra_q) begin
      // The owed cycle is spent now.
      extra_d = 1'b0;
    end else if (take) begin
      // Odd double-word after double-word, or a long float, costs two.
      extra_d = field_in.fp_double || (field_in.dword && field_in.odd && prev_dw_q);
      prev_dw_d = field_in.dword;
      cyc_d = extra_d ? `PIT_FLD_TWO : `PIT_FLD_ONE;
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      extra_q <= 1'b0;
      prev_dw_q <= 1'b0;
      cyc_q <= 2'h0;
    end else begin
      extra_q <= extra_d;
      prev_dw_q <= prev_dw_d;
      cyc_q <= cyc_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_fp_two_cycles: assert property (take && field_in.fp_double |=> !field_ready_out && cyc_q == 2'h2)
    else $error("long float not held two cycles");
  a_odd_dword_pair: assert property (take && field_in.dword && field_in.odd && prev_dw_q |=> extra_q)
    else $error("odd double-word pair did not cost a cycle");
  a_one_per_cycle: assert property (take && !field_in.fp_double && !(field_in.dword && field_in.odd)
    |=> !extra_q && cyc_q == 2'h1)
    else $error("plain field took more than one cycle");
endmodule

/* File: logic/pit_pipeline_ctrl.sv */
`timescale 1ns/1ps
`include "pit_consts.svh"
// Notes on behaviour
// - Loader takes one instruction field per cycle.
// - Odd double-word field pair costs one cycle.
// - Long float immediate takes two cycles total.
// - Address unit base time is two cycles.
// - Float ops add three plus two per quad.
// - Both general operands in memory add two.
// - Mode costs: relative 3, external 8, index 2.
// - Some ops stop address unit, some flush.
// - Base register hazard stalls three or one.
// - Stack-top updates and stopping writers never stall.
// - Index register hazard from previous stalls one.
// - Same-width source reuse is bypassed, no stall.
// - Wider source than last write stalls two.
// - Integer and float registers compared alike.
// - Memory dependency by crossing or address match.
// - Memory dependency stalls four or two cycles.
// - Write, one other, access, read sequence delays read one.
// - Branch target computed; unconditional fetches target.
// - Predict taken if backward, not-equal, less-or-equal.
// - Save alternate stream; redirect on misprediction.
// - Unconditional equals correctly predicted taken branch.
// - Back-to-back conditional branches add two cycles.
// - Advance after longer of address and execute; after a stopping op, after their sum.
module pit_pipeline_ctrl (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic field_valid_in,
  input wire pit_pkg::pit_field_t field_in,
  output logic field_ready_out,
  output logic [1:0] field_cycles_out,
  input wire logic instr_valid_in,
  input wire pit_pkg::pit_instr_t instr_in,
  output logic instr_ready_out,
  output logic [7:0] au_cycles_out,
  output logic [7:0] stall_out,
  output logic [8:0] advance_cycles_out,
  output logic flush_out,
  output logic fetch_valid_out,
  output logic [31:0] fetch_addr_out,
  input wire logic resolve_valid_in,
  input wire logic resolve_taken_in,
  output logic redirect_valid_out,
  output logic [31:0] redirect_addr_out
);
  import pit_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pit_state_t st_q, st_d; // Waiting out an advance period or idle.
  logic [8:0] cnt_q, cnt_d; // Cycles left before the next instruction.
  pit_hist_t h1_q, h1_d, h2_q, h2_d, h3_q, h3_d; // One, two and three back.
  logic [7:0] au_q, au_d; // Address unit time of the last instruction.
  logic [7:0] stall_q, stall_d; // Interlock stall of the last instruction.
  logic [8:0] adv_q, adv_d; // Whole advance period of the last instruction.
  logic flush_q, flush_d; // Queue flush pulse.
  logic fv_q, fv_d; // Fetch request pulse.
  logic [31:0] fa_q, fa_d; // Fetch address.
  logic alt_valid_q, alt_valid_d; // Alternate stream register holds a stream.
  logic alt_pred_q, alt_pred_d; // Prediction of the pending branch.
  logic [31:0] alt_addr_q, alt_addr_d; // Address of the stream not chosen.
  logic rv_q, rv_d; // Redirect pulse.
  logic [31:0] ra_q, ra_d; // Redirect address.

  // ----------------------------------------------------------------
  // Combinational cost terms
  // ----------------------------------------------------------------
  logic take; // Instruction accepted this cycle.
  logic [7:0] au_time; // Address unit time of the incoming instruction.
  logic [7:0] stall; // Largest interlock stall.
  logic [8:0] adv; // Total advance period.
  logic is_cond, is_uncond, pred_taken;
  logic [31:0] target, seq_addr;
  logic base_hit1, base_hit2, idx_hit1, width_hit, mem_hit1, mem_hit2, dc_hit, br_pair;

  // Cost added by one operand's addressing mode.
  function automatic logic [7:0] mode_cost(input pit_mode_t m);
    case (m)
      mode_mem_relative: mode_cost = `PIT_MODE_MREL;
      mode_external: mode_cost = `PIT_MODE_EXT;
      mode_scaled_index: mode_cost = `PIT_MODE_SIDX;
      default: mode_cost = 8'h00;
    endcase
  endfunction

  // Register numbers are compared without the file bit, so a float write
  // interlocks an integer read and vice versa.
  function automatic logic reg_hit(input pit_hist_t h, input logic [3:0] r);
    reg_hit = h.reg_wr && (h.dst_reg[`PIT_REG_NUM_MSB:0] == r[`PIT_REG_NUM_MSB:0]);
  endfunction

  // Conservative dependency test; false hits cost time but never data.
  function automatic logic mem_dep(input pit_hist_t h, input pit_instr_t c);
    logic lo_eq;
    logic dw_eq;
    logic wide;
    lo_eq = h.mem_addr[`PIT_ADDR_MSB:0] == c.mem_addr[`PIT_ADDR_MSB:0];
    dw_eq = h.mem_addr[`PIT_ADDR_MSB:`PIT_ADDR_DW_LSB] == c.mem_addr[`PIT_ADDR_MSB:`PIT_ADDR_DW_LSB];
    wide = (h.mem_size != `PIT_SZ_BYTE) || (c.mem_size != `PIT_SZ_BYTE);
    mem_dep = h.mem_wr && c.mem_rd && (h.mem_cross || c.mem_cross || lo_eq || (dw_eq && wide));
  endfunction

  assign instr_ready_out = ce_in && (st_q == st_idle);
  assign take = instr_valid_in && instr_ready_out;

  // Cost, interlocks and branch choice of the offered instruction.
  always_comb begin
    au_time = `PIT_AU_BASE + {4'h0, instr_in.au_extra};
    if (instr_in.fp_op) begin
      au_time = au_time + `PIT_FP_BASE + 8'(`PIT_FP_QUAD * instr_in.quad_mem);
    end
    if (instr_in.two_gen && instr_in.mem1 && instr_in.mem2) begin
      au_time = au_time + `PIT_BOTH_MEM;
    end
    au_time = au_time + mode_cost(instr_in.mode1) + mode_cost(instr_in.mode2);
    base_hit1 = instr_in.base_use && reg_hit(h1_q, instr_in.base_reg);
    base_hit2 = instr_in.base_use && reg_hit(h2_q, instr_in.base_reg);
    idx_hit1 = instr_in.idx_use && reg_hit(h1_q, instr_in.idx_reg);
    // Same or narrower reads ride the bypass; only a wider read waits.
    width_hit = instr_in.src_use && reg_hit(h1_q, instr_in.src_reg) && (instr_in.src_size > h1_q.dst_size);
    mem_hit1 = mem_dep(h1_q, instr_in);
    mem_hit2 = mem_dep(h2_q, instr_in);
    dc_hit = h3_q.mem_wr && h1_q.mem_acc && instr_in.mem_rd;
    is_cond = (instr_in.br == br_conditional) || (instr_in.br == add_compare_branch_op);
    is_uncond = (instr_in.br == unconditional_branch_op) || (instr_in.br == branch_subroutine_op);
    br_pair = is_cond && h1_q.cond_br;
    // Overlapping hazards share the wait, so the largest one counts.
    stall = 8'h00;
    if (base_hit2) stall = `PIT_STALL_BASE2;
    if (idx_hit1 && stall < `PIT_STALL_IDX1) stall = `PIT_STALL_IDX1;
    if (dc_hit && stall < `PIT_STALL_DCACHE) stall = `PIT_STALL_DCACHE;
    if (width_hit && stall < `PIT_STALL_WIDTH) stall = `PIT_STALL_WIDTH;
    if (mem_hit2 && stall < `PIT_STALL_MEM2) stall = `PIT_STALL_MEM2;
    if (br_pair && stall < `PIT_STALL_BRPAIR) stall = `PIT_STALL_BRPAIR;
    if (base_hit1 && stall < `PIT_STALL_BASE1) stall = `PIT_STALL_BASE1;
    if (mem_hit1) stall = `PIT_STALL_MEM1;
    // After a stopping instruction the two units run one after the other.
    if (h1_q.au_stop) begin
      adv = {1'b0, au_time} + {1'b0, h1_q.eu_cycles};
    end else if (au_time > h1_q.eu_cycles) begin
      adv = {1'b0, au_time};
    end else begin
      adv = {1'b0, h1_q.eu_cycles};
    end
    adv = adv + {1'b0, stall};
    target = instr_in.pc + instr_in.disp;
    seq_addr = instr_in.pc + 32'(instr_in.len);
    pred_taken = is_uncond || (is_cond && (instr_in.disp[31] || instr_in.cond == `PIT_NOT_EQUAL_CONDITION
      || instr_in.cond == `PIT_LESS_OR_EQUAL_CONDITION));
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    h1_d = h1_q;
    h2_d = h2_q;
    h3_d = h3_q;
    au_d = au_q;
    stall_d = stall_q;
    adv_d = adv_q;
    flush_d = flush_q && !ce_in;
    fv_d = fv_q && !ce_in;
    fa_d = fa_q;
    alt_valid_d = alt_valid_q;
    alt_pred_d = alt_pred_q;
    alt_addr_d = alt_addr_q;
    rv_d = rv_q && !ce_in;
    ra_d = ra_q;
    if (ce_in) begin
      // Resolution first, so a branch taken in the same cycle refills the register.
      if (resolve_valid_in && alt_valid_q) begin
        alt_valid_d = 1'b0;
        if (resolve_taken_in != alt_pred_q) begin
          rv_d = 1'b1;
          ra_d = alt_addr_q;
        end
      end
      case (st_q)
        st_idle: begin
          if (take) begin
            au_d = au_time;
            stall_d = stall;
            adv_d = adv;
            cnt_d = adv - `PIT_CNT_ONE;
            st_d = (adv > `PIT_CNT_ONE) ? st_wait : st_idle;
            flush_d = instr_in.flush;
            h3_d = h2_q;
            h2_d = h1_q;
            // Stack-top updates and stopping writers are never register hazard sources.
            h1_d.reg_wr = instr_in.dst_we && !instr_in.dst_stack_top_addressing && !instr_in.au_stop;
            h1_d.dst_reg = instr_in.dst_reg;
            h1_d.dst_size = instr_in.dst_size;
            h1_d.mem_wr = instr_in.mem_wr;
            h1_d.mem_acc = instr_in.mem_wr || instr_in.mem_rd;
            h1_d.mem_addr = instr_in.mem_addr;
            h1_d.mem_size = instr_in.mem_size;
            h1_d.mem_cross = instr_in.mem_cross;
            h1_d.eu_cycles = instr_in.eu_cycles;
            h1_d.au_stop = instr_in.au_stop;
            h1_d.cond_br = is_cond;
            if (pred_taken) begin
              fv_d = 1'b1;
              fa_d = target;
            end
            if (is_cond) begin
              alt_valid_d = 1'b1;
              alt_pred_d = pred_taken;
              alt_addr_d = pred_taken ? seq_addr : target;
            end
          end
        end
        st_wait: begin
          // Count down the advance period.
          cnt_d = cnt_q - `PIT_CNT_ONE;
          if (cnt_q == `PIT_CNT_ONE) st_d = st_idle;
        end
        default: st_d = st_idle;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= st_idle;
      cnt_q <= `PIT_CNT_ZERO;
      h1_q <= '0;
      h2_q <= '0;
      h3_q <= '0;
      au_q <= 8'h00;
      stall_q <= 8'h00;
      adv_q <= 9'h000;
      flush_q <= 1'b0;
      fv_q <= 1'b0;
      fa_q <= '0;
      alt_valid_q <= 1'b0;
      alt_pred_q <= 1'b0;
      alt_addr_q <= '0;
      rv_q <= 1'b0;
      ra_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      h1_q <= h1_d;
      h2_q <= h2_d;
      h3_q <= h3_d;
      au_q <= au_d;
      stall_q <= stall_d;
      adv_q <= adv_d;
      flush_q <= flush_d;
      fv_q <= fv_d;
      fa_q <= fa_d;
      alt_valid_q <= alt_valid_d;
      alt_pred_q <= alt_pred_d;
      alt_addr_q <= alt_addr_d;
      rv_q <= rv_d;
      ra_q <= ra_d;
    end
  end

  assign au_cycles_out = au_q;
  assign stall_out = stall_q;
  assign advance_cycles_out = adv_q;
  assign flush_out = flush_q;
  assign fetch_valid_out = fv_q;
  assign fetch_addr_out = fa_q;
  assign redirect_valid_out = rv_q;
  assign redirect_addr_out = ra_q;

  // ----------------------------------------------------------------
  // Instruction field loader
  // ----------------------------------------------------------------
  pit_field_loader u_loader (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .field_valid_in(field_valid_in),
    .field_in(field_in),
    .field_ready_out(field_ready_out),
    .field_cycles_out(field_cycles_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take_plain;
    take && !instr_in.fp_op && instr_in.au_extra == 4'h0 && instr_in.mode1 == mode_plain
      && instr_in.mode2 == mode_plain && !(instr_in.two_gen && instr_in.mem1 && instr_in.mem2);
  endsequence
  a_au_base_time: assert property (s_take_plain |=> au_q == 8'h02)
    else $error("plain address unit time is not two");
  a_au_fp_cost: assert property (take && instr_in.fp_op |=> au_q >= 8'(5 + 2 * $past(instr_in.quad_mem)))
    else $error("float address unit cost too small");
  a_base_prev: assert property (take && base_hit1 |=> stall_q >= 8'h03)
    else $error("base hazard did not stall three");
  a_index_prev: assert property (take && idx_hit1 |=> stall_q >= 8'h01)
    else $error("index hazard did not stall");
  a_mem_prev: assert property (take && mem_hit1 |=> stall_q == 8'h04)
    else $error("memory hazard did not stall four");
  a_hold_period: assert property (take && adv >= 9'h003 |=> !instr_ready_out ##1 !instr_ready_out)
    else $error("taken before period ended");
  sequence s_uncond_take;
    take && is_uncond;
  endsequence
  a_uncond_fetch: assert property (s_uncond_take |=> fetch_valid_out && fetch_addr_out == $past(target))
    else $error("unconditional branch did not fetch target");
  a_mispredict: assert property (ce_in && resolve_valid_in && alt_valid_q && resolve_taken_in != alt_pred_q
    |=> redirect_valid_out && redirect_addr_out == $past(alt_addr_q))
    else $error("misprediction did not redirect");
  a_cond_pair: assert property (take && br_pair |=> stall_q >= 8'h02)
    else $error("branch pair not delayed");
endmodule

/* File: logic/pit_pkg.sv */
package pit_pkg;
  // Addressing mode of one general operand.
  typedef enum logic [1:0] {mode_plain, mode_mem_relative, mode_external, mode_scaled_index} pit_mode_t;
  // Branch class of an instruction.
  typedef enum logic [2:0] {br_none, br_conditional, add_compare_branch_op, unconditional_branch_op,
    branch_subroutine_op} pit_br_t;
  // Pipeline controller state.
  typedef enum logic {st_idle, st_wait} pit_state_t;
  // Decoded instruction as handed to the address stage.
  typedef struct packed {
    logic [31:0] pc;
    logic [3:0] len;
    logic [31:0] disp;
    pit_br_t br;
    logic [3:0] cond;
    logic [3:0] au_extra;
    logic fp_op;
    logic [1:0] quad_mem;
    logic two_gen;
    logic mem1;
    logic mem2;
    pit_mode_t mode1;
    pit_mode_t mode2;
    logic base_use;
    logic [3:0] base_reg;
    logic idx_use;
    logic [3:0] idx_reg;
    logic src_use;
    logic [3:0] src_reg;
    logic [1:0] src_size;
    logic dst_we;
    logic dst_stack_top_addressing;
    logic [3:0] dst_reg;
    logic [1:0] dst_size;
    logic au_stop;
    logic flush;
    logic [7:0] eu_cycles;
    logic mem_rd;
    logic mem_wr;
    logic [11:0] mem_addr;
    logic [1:0] mem_size;
    logic mem_cross;
  } pit_instr_t;
  // What is remembered of an older instruction.
  typedef struct packed {
    logic reg_wr;
    logic [3:0] dst_reg;
    logic [1:0] dst_size;
    logic mem_wr;
    logic mem_acc;
    logic [11:0] mem_addr;
    logic [1:0] mem_size;
    logic mem_cross;
    logic [7:0] eu_cycles;
    logic au_stop;
    logic cond_br;
  } pit_hist_t;
  // One instruction field seen by the loader.
  typedef struct packed {
    logic dword;
    logic odd;
    logic fp_double;
  } pit_field_t;
endpackage

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`include "pit_consts.svh"
module testbench;
  import pit_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, observed outputs and tallies
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, field_valid_in = 1'b0;
  logic instr_valid_in = 1'b0, resolve_valid_in = 1'b0, resolve_taken_in = 1'b0;
  pit_field_t field_in = '0;
  pit_instr_t instr_in = '0;
  logic field_ready_out, instr_ready_out, flush_out, fetch_valid_out, redirect_valid_out;
  logic [1:0] field_cycles_out;
  logic [7:0] au_cycles_out, stall_out;
  logic [8:0] advance_cycles_out;
  logic [31:0] fetch_addr_out, redirect_addr_out;
  int err_count = 0, checked = 0;
  pit_instr_t t;
  logic p, tk;
  logic [8:0] adv_u;
  // Branch table: every class but br_none; conditionals both directions.
  pit_br_t bt [7] = '{unconditional_branch_op, branch_subroutine_op, br_conditional, br_conditional,
    br_conditional, br_conditional, add_compare_branch_op};
  logic [3:0] bc [7] = '{4'h0, 4'h0, 4'h0, `PIT_NOT_EQUAL_CONDITION, `PIT_LESS_OR_EQUAL_CONDITION, 4'h0, 4'h0};
  logic [31:0] bd [7] = '{32'h40, 32'h40, 32'h40, 32'h40, 32'h40, 32'hFFFFFFC0, 32'hFFFFFFC0};
  always #25 clk_sys_in = ~clk_sys_in;
  pit_pipeline_ctrl i_pit_pipeline_ctrl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .field_valid_in(field_valid_in), .field_in(field_in), .field_ready_out(field_ready_out),
    .field_cycles_out(field_cycles_out), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .instr_ready_out(instr_ready_out), .au_cycles_out(au_cycles_out), .stall_out(stall_out),
    .advance_cycles_out(advance_cycles_out), .flush_out(flush_out), .fetch_valid_out(fetch_valid_out),
    .fetch_addr_out(fetch_addr_out), .resolve_valid_in(resolve_valid_in), .resolve_taken_in(resolve_taken_in),
    .redirect_valid_out(redirect_valid_out), .redirect_addr_out(redirect_addr_out));
  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Case inequality lets no unknown pass as a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // Inputs move 1 ns after the edge, clear of any race.
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic issue(input pit_instr_t x);
    int n = 0;
    while (instr_ready_out !== 1'b1) begin
      tick();
      n++;
      if (n > 40) begin
        err_count++;
        close_out();
      end
    end
    instr_in = x;
    instr_valid_in = 1'b1;
    tick();
    instr_valid_in = 1'b0;
  endtask
  // Valid stays up so fields run back to back.
  task automatic fld(input logic [2:0] f, input logic [1:0] ec);
    int n = 0;
    while (field_ready_out !== 1'b1) begin
      tick();
      n++;
      if (n > 8) begin
        err_count++;
        close_out();
      end
    end
    field_in = pit_field_t'(f);
    field_valid_in = 1'b1;
    tick();
    chk(32'(field_cycles_out), 32'(ec), "field cycles");
    chk(32'(field_ready_out), 32'(ec == 2'h1), "field ready");
  endtask
  task automatic resolve(input logic taken);
    resolve_taken_in = taken;
    resolve_valid_in = 1'b1;
    tick();
    resolve_valid_in = 1'b0;
  endtask
  function automatic pit_instr_t nop();
    pit_instr_t x = '0;
    x.pc = 32'h00001000;
    x.len = 4'h4;
    x.eu_cycles = 8'h02;
    return x;
  endfunction
  function automatic pit_instr_t rw(input logic [3:0] rg, input logic [1:0] sz);
    pit_instr_t x = nop();
    x.dst_we = 1'b1;
    x.dst_reg = rg;
    x.dst_size = sz;
    return x;
  endfunction
  // Kind 0 reads as base, 1 as index, 2 as double-word source.
  function automatic pit_instr_t rd(input logic [1:0] k, input logic [3:0] rg);
    pit_instr_t x = nop();
    x.base_use = (k == 2'h0);
    x.idx_use = (k == 2'h1);
    x.src_use = (k == 2'h2);
    x.base_reg = rg;
    x.idx_reg = rg;
    x.src_reg = rg;
    x.src_size = `PIT_SZ_DWORD;
    return x;
  endfunction
  function automatic pit_instr_t mem(input logic wr, input logic [11:0] a, input logic [1:0] sz, input logic cr);
    pit_instr_t x = nop();
    x.mem_wr = wr;
    x.mem_rd = !wr;
    x.mem_addr = a;
    x.mem_size = sz;
    x.mem_cross = cr;
    return x;
  endfunction
  function automatic logic [7:0] mc(input pit_mode_t m);
    return m == mode_mem_relative ? `PIT_MODE_MREL : m == mode_external ? `PIT_MODE_EXT :
      m == mode_scaled_index ? `PIT_MODE_SIDX : 8'h00;
  endfunction
  function automatic logic [7:0] au_exp(input pit_instr_t x);
    logic [7:0] e;
    e = `PIT_AU_BASE + 8'(x.au_extra) + mc(x.mode1);
    if (x.two_gen) e += mc(x.mode2);
    if (x.two_gen && x.mem1 && x.mem2) e += `PIT_BOTH_MEM;
    if (x.fp_op) e += `PIT_FP_BASE + `PIT_FP_QUAD * 8'(x.quad_mem);
    return e;
  endfunction
  // Two plain instructions first clear older history.
  task automatic hz(input pit_instr_t w, input logic gap, input pit_instr_t r, input logic [7:0] es);
    logic [7:0] e;
    e = gap ? 8'h02 : w.eu_cycles;
    issue(nop());
    issue(nop());
    issue(w);
    if (gap) issue(nop());
    issue(r);
    chk(32'(stall_out), 32'(es), "stall");
    chk(32'(advance_cycles_out), 32'((w.au_stop && !gap) ? 8'h02 + e : ((e > 8'h02) ? e : 8'h02) + es), "advance");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7c56eba0));
    repeat (3) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    ce_in = 1'b0;
    #1;
    chk(32'(instr_ready_out), 32'h0, "ready while frozen");
    chk(32'(field_ready_out), 32'h0, "frozen field ready");
    ce_in = 1'b1;
    tick();
    fld(3'b000, 2'h1);
    fld(3'b100, 2'h1);
    fld(3'b110, 2'h2);
    fld(3'b001, 2'h2);
    fld(3'b010, 2'h1);
    fld(3'b110, 2'h1);
    field_valid_in = 1'b0;
    $display("test loader done");
    repeat (24) begin
      t = nop();
      t.au_extra = 4'($urandom_range(3, 0));
      t.fp_op = 1'($urandom_range(1, 0));
      t.quad_mem = 2'($urandom_range(2, 0));
      t.two_gen = 1'($urandom_range(1, 0));
      t.mem1 = 1'($urandom_range(1, 0));
      t.mem2 = 1'($urandom_range(1, 0));
      t.mode1 = pit_mode_t'($urandom_range(3, 0));
      t.mode2 = t.two_gen ? pit_mode_t'($urandom_range(3, 0)) : mode_plain;
      issue(t);
      chk(32'(au_cycles_out), 32'(au_exp(t)), "address unit time");
      chk(32'(advance_cycles_out), 32'(au_exp(t)), "advance");
    end
    $display("test address unit done");
    hz(rw(4'h1, `PIT_SZ_DWORD), 1'b0, rd(2'h0, 4'h1), 8'h03);
    hz(rw(4'h1, `PIT_SZ_DWORD), 1'b1, rd(2'h0, 4'h1), 8'h01);
    hz(rw(4'h1, `PIT_SZ_DWORD), 1'b0, rd(2'h1, 4'h1), 8'h01);
    hz(rw(4'h1, `PIT_SZ_DWORD), 1'b1, rd(2'h1, 4'h1), 8'h00);
    hz(rw(4'h1, `PIT_SZ_DWORD), 1'b0, rd(2'h2, 4'h1), 8'h00);
    hz(rw(4'h1, `PIT_SZ_BYTE), 1'b0, rd(2'h2, 4'h1), 8'h02);
    hz(rw(4'h9, `PIT_SZ_DWORD), 1'b0, rd(2'h0, 4'h1), 8'h03);
    t = rw(4'h1, `PIT_SZ_DWORD);
    t.dst_stack_top_addressing = 1'b1;
    hz(t, 1'b0, rd(2'h0, 4'h1), 8'h00);
    t.dst_stack_top_addressing = 1'b0;
    t.au_stop = 1'b1;
    hz(t, 1'b0, rd(2'h0, 4'h1), 8'h00);
    t = nop();
    t.eu_cycles = 8'h05;
    hz(t, 1'b0, nop(), 8'h00);
    hz(mem(1'b1, 12'h104, `PIT_SZ_BYTE, 1'b0), 1'b0, mem(1'b0, 12'h104, `PIT_SZ_BYTE, 1'b0), 8'h04);
    hz(mem(1'b1, 12'h104, `PIT_SZ_BYTE, 1'b0), 1'b1, mem(1'b0, 12'h104, `PIT_SZ_BYTE, 1'b0), 8'h02);
    hz(mem(1'b1, 12'h104, `PIT_SZ_BYTE, 1'b0), 1'b0, mem(1'b0, 12'h105, `PIT_SZ_BYTE, 1'b0), 8'h00);
    hz(mem(1'b1, 12'h104, `PIT_SZ_BYTE, 1'b0), 1'b0, mem(1'b0, 12'h106, `PIT_SZ_WORD, 1'b0), 8'h04);
    hz(mem(1'b1, 12'h104, `PIT_SZ_DWORD, 1'b0), 1'b0, mem(1'b0, 12'h107, `PIT_SZ_BYTE, 1'b0), 8'h04);
    hz(mem(1'b1, 12'h300, `PIT_SZ_BYTE, 1'b1), 1'b0, mem(1'b0, 12'h104, `PIT_SZ_BYTE, 1'b0), 8'h04);
    issue(mem(1'b1, 12'h010, `PIT_SZ_DWORD, 1'b0));
    issue(nop());
    issue(mem(1'b0, 12'h020, `PIT_SZ_DWORD, 1'b0));
    issue(mem(1'b0, 12'h030, `PIT_SZ_DWORD, 1'b0));
    chk(32'(stall_out), 32'h1, "write occupancy");
    t = nop();
    t.flush = 1'b1;
    issue(t);
    chk(32'(flush_out), 32'h1, "flush pulse");
    tick();
    chk(32'(flush_out), 32'h0, "flush pulse end");
    $display("test interlocks done");
    for (int i = 0; i < 7; i++) begin
      t = nop();
      t.br = bt[i];
      t.cond = bc[i];
      t.disp = bd[i];
      p = (i < 2) || bd[i][31] || bc[i] == `PIT_NOT_EQUAL_CONDITION || bc[i] == `PIT_LESS_OR_EQUAL_CONDITION;
      issue(nop());
      issue(t);
      chk(32'(fetch_valid_out), 32'(p), "fetch pulse");
      if (p) chk(fetch_addr_out, t.pc + t.disp, "fetch target");
      if (i == 0) adv_u = advance_cycles_out;
      if (i == 5) chk(32'(advance_cycles_out), 32'(adv_u), "branch delay");
      if (i > 1) begin
        tk = (i == 2) ? 1'b1 : 1'($urandom_range(1, 0));
        resolve(tk);
        chk(32'(redirect_valid_out), 32'(tk != p), "redirect pulse");
        if (tk != p) chk(redirect_addr_out, p ? t.pc + 32'(t.len) : t.pc + t.disp, "redirect target");
      end
    end
    t = nop();
    t.br = br_conditional;
    t.disp = 32'hFFFFFFC0;
    issue(nop());
    issue(t);
    issue(t);
    chk(32'(stall_out), 32'h2, "branch pair stall");
    resolve(1'b1);
    $display("test branches done");
    close_out();
  end
endmodule
